// [rtl/hscp_pkg.sv]
// Purpose: constants shared by the hall signal conditioning path
// Assumes: 32-bit register port, byte addresses in words of four
// Notes:   codes are offset binary around CODE_ZERO, scaled by 2^Q_SHIFT

package hscp_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_RANGE = 8'h00;
   localparam logic [7:0] ADDR_GAIN = 8'h04;
   localparam logic [7:0] ADDR_OFFSET = 8'h08;
   localparam logic [7:0] ADDR_LOWPASS = 8'h0C;
   localparam logic [7:0] ADDR_T0 = 8'h10;
   localparam logic [7:0] ADDR_TC1 = 8'h14;
   localparam logic [7:0] ADDR_TC2 = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_FILT = 8'h20;

   // ---------------------------------------------------------------
   // field layout and reset values
   // ---------------------------------------------------------------
   localparam int RANGE_W = 2;
   localparam int CODE_W = 15;
   localparam int LP_W = 3;
   localparam int COEF_W = 16;
   localparam int DAC_W = 12;
   localparam logic [1:0] RANGE_50MT = 2'h3;
   localparam logic [1:0] RANGE_100MT = 2'h1;
   localparam logic [1:0] RANGE_200MT = 2'h0;
   localparam logic [1:0] RANGE_RST = 2'h1;
   localparam logic [14:0] GAIN_RST = 15'h5000;
   localparam logic [14:0] OFFSET_RST = 15'h4800;
   localparam logic [2:0] LOWPASS_RST = 3'h7;
   localparam logic [2:0] LOWPASS_OFF = 3'h7;
   localparam logic [15:0] T0_RST = 16'h0000;
   localparam logic [15:0] TC1_RST = 16'h0000;
   localparam logic [15:0] TC2_RST = 16'h0000;
   localparam logic signed [47:0] CODE_ZERO = 48'sh000000004000;
   localparam logic signed [47:0] Q_ONE = 48'sh000000001000;
   localparam int Q_SHIFT = 12;
   localparam int LP_FRAC = 8;
   localparam logic signed [47:0] DAC_MAX = 48'sh000000000FFF;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 200000000;
   localparam int UPDATE_HZ = 16000;
   localparam int UPDATE_CYC = CLK_HZ / UPDATE_HZ;

   // ---------------------------------------------------------------
   // sequencer states, gray along the path
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      HSCP_IDLE = 2'b00,
      HSCP_COMP = 2'b01,
      HSCP_GAIN = 2'b11,
      HSCP_OUT = 2'b10
   } hscp_state_t;

endpackage : hscp_pkg

// [rtl/hscp_path.sv]
// Purpose: digital conditioning path of a programmable linear hall sensor
// Assumes: hall and temperature samples arrive synchronous to clk
// Notes:   one result per update tick, four cycles of arithmetic each

`timescale 1ns/1ps

module hscp_path
   import hscp_pkg::*;
#(
   parameter int HALL_W = 16,
   parameter int TEMP_W = 16,
   parameter int UPDATE_CYCLES = UPDATE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic signed [HALL_W-1:0] hall_sample,
   input wire logic hall_valid,
   input wire logic signed [TEMP_W-1:0] temp_sample,
   input wire logic temp_valid,
   output logic [RANGE_W-1:0] adc_range,
   output logic [DAC_W-1:0] dac_word,
   output logic dac_valid
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // only the three documented range codes are accepted
   function automatic logic range_code_ok(input logic [1:0] code);
      range_code_ok = (code == RANGE_50MT) || (code == RANGE_100MT) ||
                      (code == RANGE_200MT);
   endfunction : range_code_ok

   // offset-binary parameter code to signed q12 value
   function automatic logic signed [47:0] code_to_q(input logic [CODE_W-1:0] code);
      code_to_q = $signed({33'h000000000, code}) - CODE_ZERO;
   endfunction : code_to_q

   // signed q12 product, scaled back to q12
   function automatic logic signed [47:0] q_mul(input logic signed [47:0] a,
                                                 input logic signed [47:0] b);
      logic signed [47:0] p;
      p = a * b;
      q_mul = p >>> Q_SHIFT;
   endfunction : q_mul

   // ---------------------------------------------------------------
   // parameter registers
   // ---------------------------------------------------------------
   logic [RANGE_W-1:0] field_range_select;
   logic [CODE_W-1:0] gain_word;
   logic [CODE_W-1:0] offset_code;
   logic [LP_W-1:0] lowpass_setting;
   logic signed [COEF_W-1:0] temp_zero_point;
   logic signed [COEF_W-1:0] first_order_temp_coeff;
   logic signed [COEF_W-1:0] second_order_temp_coeff;

   logic wr_range;
   logic wr_gain;
   logic wr_offset;
   logic wr_lowpass;
   logic wr_t0;
   logic wr_tc1;
   logic wr_tc2;

   // write decode
   assign wr_range = reg_wr && (reg_addr == ADDR_RANGE);
   assign wr_gain = reg_wr && (reg_addr == ADDR_GAIN);
   assign wr_offset = reg_wr && (reg_addr == ADDR_OFFSET);
   assign wr_lowpass = reg_wr && (reg_addr == ADDR_LOWPASS);
   assign wr_t0 = reg_wr && (reg_addr == ADDR_T0);
   assign wr_tc1 = reg_wr && (reg_addr == ADDR_TC1);
   assign wr_tc2 = reg_wr && (reg_addr == ADDR_TC2);

   // range register; an undefined code is dropped so the adc never sees it
   always_ff @(posedge clk) begin
      if (rst) begin
         field_range_select <= RANGE_RST;
      end else if (wr_range && range_code_ok(reg_wdata[RANGE_W-1:0])) begin
         field_range_select <= reg_wdata[RANGE_W-1:0];
      end
   end

   // gain and offset codes; no ordering is enforced against the range
   always_ff @(posedge clk) begin
      if (rst) begin
         gain_word <= GAIN_RST;
         offset_code <= OFFSET_RST;
      end else begin
         if (wr_gain) begin
            gain_word <= reg_wdata[CODE_W-1:0];
         end
         if (wr_offset) begin
            offset_code <= reg_wdata[CODE_W-1:0];
         end
      end
   end

   // filter and temperature compensation settings
   always_ff @(posedge clk) begin
      if (rst) begin
         lowpass_setting <= LOWPASS_RST;
         temp_zero_point <= T0_RST;
         first_order_temp_coeff <= TC1_RST;
         second_order_temp_coeff <= TC2_RST;
      end else begin
         if (wr_lowpass) begin
            lowpass_setting <= reg_wdata[LP_W-1:0];
         end
         if (wr_t0) begin
            temp_zero_point <= reg_wdata[COEF_W-1:0];
         end
         if (wr_tc1) begin
            first_order_temp_coeff <= reg_wdata[COEF_W-1:0];
         end
         if (wr_tc2) begin
            second_order_temp_coeff <= reg_wdata[COEF_W-1:0];
         end
      end
   end

   // range goes straight to the converter front end
   assign adc_range = field_range_select;

   // ---------------------------------------------------------------
   // input low-pass filter
   // ---------------------------------------------------------------
   localparam int ACC_W = HALL_W + LP_FRAC;
   logic signed [HALL_W-1:0] hall_sym;
   logic signed [ACC_W-1:0] hall_ext;
   logic signed [ACC_W-1:0] lp_acc;
   logic signed [ACC_W-1:0] lp_step;
   logic signed [ACC_W:0] lp_diff;
   logic signed [ACC_W:0] lp_shifted;
   logic [LP_W-1:0] lp_shift;
   logic signed [HALL_W-1:0] lp_out;

   // most negative code folded up so both field limits match
   always_comb begin
      if (hall_sample == {1'b1, {(HALL_W-1){1'b0}}}) begin
         hall_sym = {1'b1, {(HALL_W-2){1'b0}}, 1'b1};
      end else begin
         hall_sym = hall_sample;
      end
      hall_ext = {hall_sym, {LP_FRAC{1'b0}}};
      // low settings take small steps, i.e. the narrowest bandwidth
      lp_shift = LOWPASS_OFF - lowpass_setting;
      // one guard bit: input and state may sit at opposite full scale
      lp_diff = {hall_ext[ACC_W-1], hall_ext} - {lp_acc[ACC_W-1], lp_acc};
      lp_shifted = lp_diff >>> lp_shift;
      // at least one shift when filtering, so the step fits the accumulator
      lp_step = lp_shifted[ACC_W-1:0];
   end

   // first-order recursive filter, unity dc gain, bypassed at setting 7
   always_ff @(posedge clk) begin
      if (rst) begin
         lp_acc <= '0;
      end else if (hall_valid) begin
         if (lowpass_setting == LOWPASS_OFF) begin
            lp_acc <= hall_ext;
         end else begin
            lp_acc <= lp_acc + lp_step;
         end
      end
   end

   assign lp_out = lp_acc[ACC_W-1:LP_FRAC];

   // ---------------------------------------------------------------
   // update rate tick
   // ---------------------------------------------------------------
   logic [31:0] tick_cnt;
   logic tick;

   assign tick = (tick_cnt == 32'(UPDATE_CYCLES - 1));

   // free running divider for the filtered sample rate
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 32'h00000001;
      end
   end

   // ---------------------------------------------------------------
   // temperature capture
   // ---------------------------------------------------------------
   logic signed [TEMP_W-1:0] temp_hold;

   // last converted temperature stays until the next conversion
   always_ff @(posedge clk) begin
      if (rst) begin
         temp_hold <= '0;
      end else if (temp_valid) begin
         temp_hold <= temp_sample;
      end
   end

   // ---------------------------------------------------------------
   // arithmetic sequencer
   // ---------------------------------------------------------------
   hscp_state_t state;
   hscp_state_t next_state;
   logic signed [47:0] hall_r;
   logic signed [47:0] dt_r;
   logic signed [47:0] lin_r;
   logic signed [47:0] sq_r;
   logic signed [47:0] eff_r;
   logic signed [47:0] factor;
   logic signed [47:0] amp;
   logic signed [47:0] sum;
   logic [DAC_W-1:0] limited;
   logic signed [HALL_W-1:0] filt_r;

   // state order: sample, temperature terms, gain, output
   always_comb begin
      case (state)
         HSCP_IDLE: next_state = tick ? HSCP_COMP : HSCP_IDLE;
         HSCP_COMP: next_state = HSCP_GAIN;
         HSCP_GAIN: next_state = HSCP_OUT;
         HSCP_OUT: next_state = HSCP_IDLE;
         default: next_state = HSCP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= HSCP_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // combinational tails of the gain and output stages
   always_comb begin
      // unity plus both compensation terms, all q12
      factor = Q_ONE + lin_r + q_mul(sq_r, 48'(second_order_temp_coeff));
      amp = q_mul(hall_r, eff_r);
      sum = amp + code_to_q(offset_code);
      if (sum < 48'sh0) begin
         limited = '0;
      end else if (sum > DAC_MAX) begin
         limited = DAC_MAX[DAC_W-1:0];
      end else begin
         limited = sum[DAC_W-1:0];
      end
   end

   // filtered sample and normalised temperature taken on the tick
   always_ff @(posedge clk) begin
      if (rst) begin
         hall_r <= '0;
         dt_r <= '0;
         filt_r <= '0;
      end else if (state == HSCP_IDLE && tick) begin
         hall_r <= 48'(lp_out);
         filt_r <= lp_out;
         dt_r <= 48'(temp_hold) - 48'(temp_zero_point);
      end
   end

   // linear and squared temperature terms
   always_ff @(posedge clk) begin
      if (rst) begin
         lin_r <= '0;
         sq_r <= '0;
      end else if (state == HSCP_COMP) begin
         lin_r <= q_mul(dt_r, 48'(first_order_temp_coeff));
         sq_r <= q_mul(dt_r, dt_r);
      end
   end

   // effective multiplier; gain below one half loses precision here
   always_ff @(posedge clk) begin
      if (rst) begin
         eff_r <= '0;
      end else if (state == HSCP_GAIN) begin
         eff_r <= q_mul(code_to_q(gain_word), factor);
      end
   end

   // dac word held between updates, strobe for one cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         dac_word <= '0;
         dac_valid <= 1'b0;
      end else begin
         dac_valid <= (state == HSCP_OUT);
         if (state == HSCP_OUT) begin
            dac_word <= limited;
         end
      end
   end

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------

   // data stand only in the cycle after the strobe, zero elsewhere
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_RANGE: reg_rdata <= {30'h00000000, field_range_select};
            ADDR_GAIN: reg_rdata <= {17'h00000, gain_word};
            ADDR_OFFSET: reg_rdata <= {17'h00000, offset_code};
            ADDR_LOWPASS: reg_rdata <= {29'h00000000, lowpass_setting};
            ADDR_T0: reg_rdata <= {16'h0000, temp_zero_point};
            ADDR_TC1: reg_rdata <= {16'h0000, first_order_temp_coeff};
            ADDR_TC2: reg_rdata <= {16'h0000, second_order_temp_coeff};
            ADDR_STATUS: reg_rdata <= {14'h0000, state, 4'h0, dac_word};
            ADDR_FILT: reg_rdata <= {{(32-HALL_W){filt_r[HALL_W-1]}}, filt_r};
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule : hscp_path

// [sim/hscp_path_sva.sv]
// Purpose: port checker for the hall conditioning path
// Assumes: UPDATE_CYCLES equals that of the bound instance
// Notes:   bound to every hscp_path below the module
`timescale 1ns/1ps

module hscp_path_sva
   import hscp_pkg::*;
#(
   parameter int UPDATE_CYCLES = UPDATE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [RANGE_W-1:0] adc_range,
   input wire logic [DAC_W-1:0] dac_word,
   input wire logic dac_valid
);
   // ---------------------------------------------------------------
   // helper: edges since the last result
   // ---------------------------------------------------------------
   int gap;
   logic seen;
   wire logic [1:0] wr_code = reg_wdata[1:0];

   // counter kept small: a repetition of thousands would crawl
   always_ff @(posedge clk) begin
      if (rst) begin
         gap <= 0;
         seen <= 1'b0;
      end else if (dac_valid) begin
         gap <= 1;
         seen <= 1'b1;
      end else begin
         gap <= gap + 1;
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_valid_gap;
      @(posedge clk) disable iff (rst) dac_valid |=> !dac_valid [*8];
   endproperty
   a_valid_gap: assert property (p_valid_gap) else $error("result pulse too long");

   property p_period;
      @(posedge clk) disable iff (rst) dac_valid && seen |-> gap == UPDATE_CYCLES;
   endproperty
   a_period: assert property (p_period) else $error("update spacing wrong");

   property p_first;
      @(posedge clk) disable iff (rst)
         dac_valid && !seen |-> gap >= UPDATE_CYCLES && gap <= UPDATE_CYCLES + 4;
   endproperty
   a_first: assert property (p_first) else $error("first update mistimed");

   property p_hold;
      @(posedge clk) disable iff (rst) !dac_valid |-> $stable(dac_word);
   endproperty
   a_hold: assert property (p_hold) else $error("dac word moved between updates");

   property p_range_legal;
      @(posedge clk) disable iff (rst) adc_range != 2'h2;
   endproperty
   a_range_legal: assert property (p_range_legal) else $error("range code 2 seen");

   property p_range_wr;
      @(posedge clk) disable iff (rst)
         reg_wr && reg_addr == ADDR_RANGE && wr_code != 2'h2 |=> adc_range == $past(wr_code);
   endproperty
   a_range_wr: assert property (p_range_wr) else $error("range write lost");

   property p_range_keep;
      @(posedge clk) disable iff (rst)
         reg_wr && reg_addr == ADDR_RANGE && wr_code == 2'h2 |=> $stable(adc_range);
   endproperty
   a_range_keep: assert property (p_range_keep) else $error("range code 2 taken");

   property p_status;
      @(posedge clk) disable iff (rst)
         reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[11:0] == $past(dac_word);
   endproperty
   a_status: assert property (p_status) else $error("status word mismatch");

endmodule : hscp_path_sva

bind hscp_path hscp_path_sva #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_sva (
   .clk(clk),
   .rst(rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .adc_range(adc_range),
   .dac_word(dac_word),
   .dac_valid(dac_valid)
);

// [sim/hscp_mcu_model.sv]
// Purpose: microcontroller converter reading the ratiometric output
// Assumes: output voltage is dac code over 4096 of supply
// Notes:   reads once, one cycle after each update
`timescale 1ns/1ps

module hscp_mcu_model
   import hscp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [DAC_W-1:0] dac_word,
   input wire logic dac_valid,
   output logic [DAC_W-1:0] mcu_code,
   output logic mcu_valid
);
   // supply is the converter reference, so it cancels and code equals word
   always_ff @(posedge clk) begin
      if (rst) begin
         mcu_valid <= 1'b0;
         mcu_code <= 12'h000;
      end else begin
         mcu_valid <= dac_valid;
         if (dac_valid) begin
            mcu_code <= dac_word;
         end
      end
   end
endmodule : hscp_mcu_model

// [sim/hscp_path_tb_top.sv]
// Purpose: self-checking bench of the hall conditioning path
// Assumes: filter off while results are predicted
// Notes:   short update period keeps the run brief
`timescale 1ns/1ps

module hscp_path_tb_top
   import hscp_pkg::*;
;
   localparam int UC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic signed [15:0] hall_sample = 16'sh0;
   logic hall_valid = 1'b0;
   logic signed [15:0] temp_sample = 16'sh0;
   logic temp_valid = 1'b0;
   logic [1:0] adc_range;
   logic [11:0] dac_word;
   logic dac_valid;
   logic [11:0] mcu_code;
   logic mcu_valid;
   logic rd_d = 1'b0;
   logic [31:0] rq[$];
   logic [11:0] dq[$];
   logic [31:0] lfsr = 32'hDE38;
   logic [31:0] r;
   logic [11:0] last_dac = 12'h000;
   int failures = 0;
   int n_checks = 0;
   int i;

   always #2.5 clk = ~clk;

   hscp_path #(.UPDATE_CYCLES(UC)) u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .hall_sample(hall_sample), .hall_valid(hall_valid), .temp_sample(temp_sample),
      .temp_valid(temp_valid), .adc_range(adc_range), .dac_word(dac_word),
      .dac_valid(dac_valid));
   hscp_mcu_model u_mcu (.clk(clk), .rst(rst), .dac_word(dac_word), .dac_valid(dac_valid),
      .mcu_code(mcu_code), .mcu_valid(mcu_valid));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
      return lfsr;
   endfunction : rnd

   // q12 arithmetic, floors on every shift
   function automatic logic [11:0] predict(input longint g, o, h, dt, c1, c2);
      longint f;
      longint s;
      f = 4096 + ((dt * c1) >>> 12) + ((((dt * dt) >>> 12) * c2) >>> 12);
      s = ((h * (((g - 16384) * f) >>> 12)) >>> 12) + o - 16384;
      return (s < 0) ? 12'h000 : ((s > 4095) ? 12'hFFF : s[11:0]);
   endfunction : predict

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic wait_upd();
      int k;
      for (k = 0; k < 4 * UC && mcu_valid !== 1'b1; k++) @(negedge clk);
      if (mcu_valid !== 1'b1) failures++;
   endtask : wait_upd

   // one calibration point: first update flushes, second is predicted
   task automatic vec(input logic [14:0] g, o, input logic signed [15:0] h, t, t0, c1, c2);
      wr(ADDR_GAIN, {17'h0, g});
      wr(ADDR_OFFSET, {17'h0, o});
      wr(ADDR_T0, 32'(t0));
      wr(ADDR_TC1, 32'(c1));
      wr(ADDR_TC2, 32'(c2));
      @(posedge clk);
      hall_sample <= h;
      temp_sample <= t;
      @(negedge clk);
      wait_upd();
      @(posedge clk);
      last_dac = predict(g, o, h, longint'(t) - longint'(t0), c1, c2);
      dq.push_back(last_dac);
      @(negedge clk);
      wait_upd();
      // the most negative code reads back folded by one step
      rd(ADDR_FILT, (h == 16'sh8000) ? 32'hFFFF8001 : 32'(h));
   endtask : vec

   // ---------------------------------------------------------------
   // monitor: oldest note against each result
   // ---------------------------------------------------------------
   always @(posedge clk) rd_d <= reg_rd;
   always @(negedge clk) begin
      if (rd_d && rq.size() > 0) cmp("reg_rdata", rq.pop_front(), reg_rdata);
      if (mcu_valid && dq.size() > 0) cmp("dac", {20'h0, dq.pop_front()}, {20'h0, mcu_code});
   end

   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize

   // watchdog well beyond the expected few hundred cycles
   initial begin
      #(5 * 50000);
      failures++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      hall_valid <= 1'b1;
      temp_valid <= 1'b1;
      rd(ADDR_RANGE, 32'h1);
      rd(ADDR_GAIN, 32'h5000);
      rd(ADDR_OFFSET, 32'h4800);
      rd(ADDR_LOWPASS, 32'h7);
      rd(ADDR_TC2, 32'h0);
      rd(8'h40, 32'h0);
      // range codes 3,2,1,0 written first; code 2 is refused
      for (i = 0; i < 4; i++) begin
         wr(ADDR_RANGE, 32'(3 - i));
         rd(ADDR_RANGE, (i == 1) ? 32'h3 : 32'(3 - i));
         cmp("adc_range", (i == 1) ? 32'h3 : 32'(3 - i), {30'h0, adc_range});
      end
      for (i = 0; i < 8; i++) begin
         wr(ADDR_LOWPASS, 32'(i));
         rd(ADDR_LOWPASS, 32'(i));
      end
      vec(15'h5000, 15'h4800, 16'sd1000, 0, 0, 0, 0);
      vec(15'h6000, 15'h44D2, 16'sd0, 0, 0, 0, 0);
      vec(15'h7FFF, 15'h4800, 16'sd20000, 0, 0, 0, 0);
      vec(15'h0000, 15'h4800, 16'sd20000, 0, 0, 0, 0);
      vec(15'h5000, 15'h4800, 16'sh8000, 0, 0, 0, 0);
      vec(15'h5000, 15'h4000, 16'sd3000, 16'sd612, 16'sd100, 16'sh0800, 16'sh0400);
      // random calibration points, gain kept at or above one half in magnitude
      for (i = 0; i < 4; i++) begin
         r = rnd();
         vec(15'h4800 + r[12:0], 15'h3C00 + r[27:16], 16'($signed(r[13:0])),
            16'($signed(r[10:4])), 16'($signed(r[31:26])), 16'($signed(r[11:0])),
            16'($signed(r[19:8])));
      end
      // sequencer idle here, word held since the last predicted update
      rd(ADDR_STATUS, {14'h0000, HSCP_IDLE, 4'h0, last_dac});
      // let the monitor see the last read before the verdict
      repeat (2) @(posedge clk);
      if (rq.size() != 0 || dq.size() != 0) failures++;
      summarize();
   end
endmodule : hscp_path_tb_top
